// file: hw/axm_pkg.sv
// Package of constants and types for the auxiliary sensor bus master.
package axm_pkg;
    // Core clock period in picoseconds (200 MHz).
    localparam int unsigned AXM_CLK_PERIOD_PS = 5000;
    // Sensor bus half period of SCL, in nanoseconds.
    localparam int unsigned AXM_HALF_PERIOD_NS = 1250;
    // Cycles per quarter of an SCL period, rounded down, at least one.
    localparam int unsigned AXM_QTR_CYCLES =
        (AXM_HALF_PERIOD_NS * 1000 / AXM_CLK_PERIOD_PS) / 2 > 0 ?
        (AXM_HALF_PERIOD_NS * 1000 / AXM_CLK_PERIOD_PS) / 2 : 1;
    // Bytes per magnetometer axis and number of axes in a burst.
    localparam int unsigned AXM_BYTES_PER_AXIS = 2;
    localparam int unsigned AXM_AXES           = 3;
    // Default read burst length (X, Y and Z).
    localparam logic [7:0] AXM_BURST_LEN = 8'(AXM_BYTES_PER_AXIS * AXM_AXES);
    // Default FIFO shape.
    localparam int unsigned AXM_FIFO_DEPTH = 8;
    localparam int unsigned AXM_FIFO_WIDTH = 8;
    // Bus operating modes.
    typedef enum logic [0:0] {
        AXM_MODE_MASTER = 1'b0,
        AXM_MODE_PASS   = 1'b1
    } axm_mode_t;
    // Bit engine states.
    typedef enum logic [3:0] {
        AXM_ST_IDLE  = 4'h0,
        AXM_ST_START = 4'h1,
        AXM_ST_ADDR  = 4'h2,
        AXM_ST_AACK  = 4'h3,
        AXM_ST_REG   = 4'h4,
        AXM_ST_RACK  = 4'h5,
        AXM_ST_RSTRT = 4'h6,
        AXM_ST_RADDR = 4'h7,
        AXM_ST_RAACK = 4'h8,
        AXM_ST_READ  = 4'h9,
        AXM_ST_MACK  = 4'hA,
        AXM_ST_STOP  = 4'hB
    } axm_state_t;
endpackage

// file: hw/axm_stream_if.sv
// Interface carrying a valid/ready byte stream between design modules.
`timescale 1ns/1ps
`default_nettype none
interface axm_stream_if #(parameter int unsigned WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: hw/axm_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module axm_fifo
    import axm_pkg::*;
#(
    parameter int unsigned WIDTH = AXM_FIFO_WIDTH,
    parameter int unsigned DEPTH = AXM_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    // Fill side.
    axm_stream_if.snk wr,
    // Drain side.
    axm_stream_if.src rd
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;
    logic [WIDTH-1:0] head_word;

    // Handshakes: honest full and empty.
    assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_r != '0);
    assign rd.data  = head_word;
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    // Pointer and count next values.
    always_comb begin
        wp_nxt  = push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Pointer and count registers.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage array; head word is presented from the read pointer.
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wp_r] <= wr.data;
        end
    end
    always_comb head_word = mem[rp_r];
endmodule
`default_nettype wire

// file: hw/axm_aux_master.sv
// Auxiliary sensor bus unit: read master with FIFO, or pass-through to host bus.
// How it works
// - Two modes only: internal read master, or pass-through joining host and sensor buses.
// - Pass-through disables the master and routes host bus lines onto sensor pins.
// - Master fetches sensor data itself once triggered; no host traffic per access.
// - Burst reads of X, Y, Z, two bytes each, supported by length setting.
// - SPI host link forces master mode; pass-through is never offered.
// - Master performs single-byte and multi-byte reads on the sensor bus.
// - Host side is only ever a slave; this unit never drives host clock.
`timescale 1ns/1ps
`default_nettype none
module axm_aux_master
    import axm_pkg::*;
#(
    parameter int unsigned QTR   = AXM_QTR_CYCLES,
    parameter int unsigned DEPTH = AXM_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    // Mode selection.
    input  wire logic       i_pass_req,
    input  wire logic       i_host_is_spi,
    // Read request from the on-chip processor.
    input  wire logic       i_rd_start,
    input  wire logic [6:0] i_rd_dev,
    input  wire logic [7:0] i_rd_reg,
    input  wire logic [7:0] i_rd_len,
    output logic            o_busy,
    output logic            o_nack,
    // Read data stream.
    output logic            o_data_valid,
    output logic [7:0]      o_data,
    input  wire logic       i_data_ready,
    // Host bus lines (slave side of the primary bus).
    input  wire logic       i_host_scl,
    input  wire logic       i_host_sda,
    output logic            o_host_sda_oe_n,
    // Sensor bus pins, open drain.
    input  wire logic       i_sensor_bus_clock_pin,
    output logic            o_sensor_bus_clock_pin,
    output logic            o_sensor_bus_clock_pin_oe_n,
    input  wire logic       i_sensor_bus_data_pin,
    output logic            o_sensor_bus_data_pin,
    output logic            o_sensor_bus_data_pin_oe_n
);
    axm_stream_if #(.WIDTH(8)) wr_s ();
    axm_stream_if #(.WIDTH(8)) rd_s ();

    axm_mode_t  mode_r, mode_nxt;
    axm_state_t st_r, st_nxt;
    logic [15:0] tick_r, tick_nxt;
    logic [1:0]  ph_r, ph_nxt;
    logic [2:0]  bit_r, bit_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic [7:0]  left_r, left_nxt;
    logic [6:0]  dev_r, dev_nxt;
    logic [7:0]  reg_r, reg_nxt;
    logic        scl_r, scl_nxt, sda_r, sda_nxt, nack_r, nack_nxt;
    logic        push, qend;

    // Mode may change only while the engine is idle; SPI host link forbids pass-through.
    always_comb begin
        mode_nxt = mode_r;
        if (st_r == AXM_ST_IDLE) begin
            mode_nxt = (i_pass_req && !i_host_is_spi) ? AXM_MODE_PASS : AXM_MODE_MASTER;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mode_r <= AXM_MODE_MASTER;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // A bit is four quarter phases; a quarter ends when the tick counter expires.
    assign qend = (tick_r == 16'(QTR - 1));
    // Bytes enter the FIFO at the end of each read byte; a full FIFO stalls the clock.
    assign wr_s.valid = push;
    assign wr_s.data  = sh_r;

    // Bit engine next state.
    always_comb begin
        st_nxt   = st_r;
        tick_nxt = tick_r;
        ph_nxt   = ph_r;
        bit_nxt  = bit_r;
        sh_nxt   = sh_r;
        left_nxt = left_r;
        dev_nxt  = dev_r;
        reg_nxt  = reg_r;
        scl_nxt  = scl_r;
        sda_nxt  = sda_r;
        nack_nxt = nack_r;
        push     = 1'b0;
        if (st_r == AXM_ST_IDLE) begin
            tick_nxt = '0;
            ph_nxt   = '0;
            scl_nxt  = 1'b1;
            sda_nxt  = 1'b1;
            if (i_rd_start && mode_r == AXM_MODE_MASTER && i_rd_len != '0) begin
                st_nxt   = AXM_ST_START;
                dev_nxt  = i_rd_dev;
                reg_nxt  = i_rd_reg;
                left_nxt = i_rd_len;
                nack_nxt = 1'b0;
            end
        end else if (!(st_r == AXM_ST_MACK && ph_r == 2'd0 && !wr_s.ready && qend) &&
                     !(scl_r && !i_sensor_bus_clock_pin)) begin
            // A sensor that holds SCL low after we release it stretches the bit.
            tick_nxt = qend ? '0 : tick_r + 16'h0001;
            if (qend) begin
                ph_nxt = ph_r + 2'd1;
                // Clock shape: low in phases 0 and 1, high in 2 and 3, so SDA moves
                // only while SCL is low and is read in the middle of the high time.
                scl_nxt = (ph_r == 2'd1) || (ph_r == 2'd2);
                unique case (st_r)
                    AXM_ST_START, AXM_ST_RSTRT: begin
                        // A fresh start keeps SCL high from idle; SDA falls in phase 3.
                        if (ph_r == 2'd0 && st_r == AXM_ST_START) scl_nxt = 1'b1;
                        if (ph_r == 2'd0) sda_nxt = 1'b1;
                        if (ph_r == 2'd2) sda_nxt = 1'b0;
                        if (ph_r == 2'd3) begin
                            st_nxt  = (st_r == AXM_ST_START) ? AXM_ST_ADDR : AXM_ST_RADDR;
                            sh_nxt  = {dev_r, (st_r == AXM_ST_RSTRT)};
                            bit_nxt = 3'd7;
                        end
                    end
                    AXM_ST_ADDR, AXM_ST_REG, AXM_ST_RADDR: begin
                        if (ph_r == 2'd0) sda_nxt = sh_r[7];
                        if (ph_r == 2'd3) begin
                            sh_nxt  = {sh_r[6:0], 1'b0};
                            bit_nxt = bit_r - 3'd1;
                            if (bit_r == 3'd0) begin
                                st_nxt = (st_r == AXM_ST_ADDR) ? AXM_ST_AACK :
                                         (st_r == AXM_ST_REG) ? AXM_ST_RACK : AXM_ST_RAACK;
                            end
                        end
                    end
                    AXM_ST_AACK, AXM_ST_RACK, AXM_ST_RAACK: begin
                        if (ph_r == 2'd0) sda_nxt = 1'b1;
                        if (ph_r == 2'd2 && i_sensor_bus_data_pin) nack_nxt = 1'b1;
                        if (ph_r == 2'd3) begin
                            bit_nxt = 3'd7;
                            if (nack_r) begin
                                st_nxt = AXM_ST_STOP;
                            end else if (st_r == AXM_ST_AACK) begin
                                st_nxt = AXM_ST_REG;
                                sh_nxt = reg_r;
                            end else if (st_r == AXM_ST_RACK) begin
                                st_nxt = AXM_ST_RSTRT;
                            end else begin
                                st_nxt = AXM_ST_READ;
                            end
                        end
                    end
                    AXM_ST_READ: begin
                        if (ph_r == 2'd0) sda_nxt = 1'b1;
                        if (ph_r == 2'd2) sh_nxt = {sh_r[6:0], i_sensor_bus_data_pin};
                        if (ph_r == 2'd3) begin
                            bit_nxt = bit_r - 3'd1;
                            if (bit_r == 3'd0) begin
                                st_nxt   = AXM_ST_MACK;
                                left_nxt = left_r - 8'd1;
                            end
                        end
                    end
                    AXM_ST_MACK: begin
                        if (ph_r == 2'd0) begin
                            push    = 1'b1;
                            sda_nxt = (left_r == '0); // Last byte is not acknowledged.
                        end
                        if (ph_r == 2'd3) begin
                            bit_nxt = 3'd7;
                            st_nxt  = (left_r == '0) ? AXM_ST_STOP : AXM_ST_READ;
                        end
                    end
                    AXM_ST_STOP: begin
                        if (ph_r == 2'd0) sda_nxt = 1'b0;
                        if (ph_r == 2'd2) sda_nxt = 1'b1;
                        if (ph_r == 2'd3) begin
                            st_nxt  = AXM_ST_IDLE;
                            scl_nxt = 1'b1;
                        end
                    end
                    default: st_nxt = AXM_ST_IDLE;
                endcase
            end
        end
    end

    // Bit engine registers.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_r   <= AXM_ST_IDLE;
            tick_r <= '0;
            ph_r   <= '0;
            bit_r  <= '0;
            sh_r   <= '0;
            left_r <= '0;
            dev_r  <= '0;
            reg_r  <= '0;
            scl_r  <= 1'b1;
            sda_r  <= 1'b1;
            nack_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            tick_r <= tick_nxt;
            ph_r   <= ph_nxt;
            bit_r  <= bit_nxt;
            sh_r   <= sh_nxt;
            left_r <= left_nxt;
            dev_r  <= dev_nxt;
            reg_r  <= reg_nxt;
            scl_r  <= scl_nxt;
            sda_r  <= sda_nxt;
            nack_r <= nack_nxt;
        end
    end

    // Pin steering: the switch joins host lines to sensor pins in pass-through.
    always_comb begin
        if (mode_r == AXM_MODE_PASS) begin
            o_sensor_bus_clock_pin_oe_n = i_host_scl;
            o_sensor_bus_data_pin_oe_n  = i_host_sda;
            o_host_sda_oe_n             = i_sensor_bus_data_pin;
        end else begin
            o_sensor_bus_clock_pin_oe_n = scl_r;
            o_sensor_bus_data_pin_oe_n  = sda_r;
            o_host_sda_oe_n             = 1'b1;
        end
    end
    // Open drain: only a low is ever driven; host clock is never driven.
    assign o_sensor_bus_clock_pin = 1'b0;
    assign o_sensor_bus_data_pin  = 1'b0;
    assign o_busy = (st_r != AXM_ST_IDLE);
    assign o_nack = nack_r;

    // Read data FIFO.
    axm_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .wr        (wr_s),
        .rd        (rd_s)
    );
    assign o_data_valid = rd_s.valid;
    assign o_data       = rd_s.data;
    assign rd_s.ready   = i_data_ready;
endmodule
`default_nettype wire

// file: sim/axm_aux_master_assertions.sv
// Assertion checker for the auxiliary sensor bus unit.
`timescale 1ns/1ps
`default_nettype none
module axm_aux_master_assertions
    import axm_pkg::*;
#(
    parameter int unsigned QTR   = AXM_QTR_CYCLES,
    parameter int unsigned DEPTH = AXM_FIFO_DEPTH
) (
    // Clock, reset and requests.
    input wire logic       i_clock,
    input wire logic       i_sys_rst,
    input wire logic       i_pass_req,
    input wire logic       i_host_is_spi,
    input wire logic       i_rd_start,
    input wire logic [7:0] i_rd_len,
    input wire logic       i_data_ready,
    // Observed outputs.
    input wire logic       o_busy,
    input wire logic       o_nack,
    input wire logic       o_data_valid,
    input wire logic [7:0] o_data,
    input wire logic       o_host_sda_oe_n,
    input wire logic       o_sensor_bus_clock_pin_oe_n,
    input wire logic       o_sensor_bus_data_pin_oe_n
);
    // Every check runs on the core clock and rests during reset.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // A start condition is on the pins within one bit time of busy rising.
    localparam int START_LIM = 4 * QTR;
    a_reset_quiet: assert property ($fell(i_sys_rst) |-> !o_busy && !o_nack
        && !o_data_valid && o_sensor_bus_clock_pin_oe_n && o_sensor_bus_data_pin_oe_n)
        else $error("unit not quiet after reset");
    a_start_taken: assert property (!o_busy && i_rd_start && i_host_is_spi
        && i_rd_len != 8'h00 |=> o_busy) else $error("read request not taken");
    a_empty_refused: assert property (!o_busy && i_rd_len == 8'h00 |=> !o_busy)
        else $error("empty read started");
    a_pass_refused: assert property ((i_pass_req && !i_host_is_spi && !o_busy)[*2]
        |=> !o_busy) else $error("master ran in pass-through");
    a_idle_released: assert property (!o_busy && $past(!o_busy) && i_host_is_spi
        |-> o_sensor_bus_clock_pin_oe_n && o_sensor_bus_data_pin_oe_n)
        else $error("idle master drives the sensor bus");
    a_spi_no_host: assert property (i_host_is_spi && $past(i_host_is_spi)
        |-> o_host_sda_oe_n) else $error("host data pulled in spi mode");
    a_data_held: assert property (o_data_valid && !i_data_ready
        |=> o_data_valid && $stable(o_data)) else $error("unread byte lost");
    a_start_seen: assert property ($rose(o_busy) |-> ##[1:START_LIM]
        (!o_sensor_bus_data_pin_oe_n && o_sensor_bus_clock_pin_oe_n))
        else $error("no start condition");
endmodule
bind axm_aux_master axm_aux_master_assertions #(.QTR(QTR), .DEPTH(DEPTH)) chk_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pass_req(i_pass_req),
    .i_host_is_spi(i_host_is_spi), .i_rd_start(i_rd_start), .i_rd_len(i_rd_len),
    .i_data_ready(i_data_ready), .o_busy(o_busy), .o_nack(o_nack),
    .o_data_valid(o_data_valid), .o_data(o_data), .o_host_sda_oe_n(o_host_sda_oe_n),
    .o_sensor_bus_clock_pin_oe_n(o_sensor_bus_clock_pin_oe_n),
    .o_sensor_bus_data_pin_oe_n(o_sensor_bus_data_pin_oe_n));
`default_nettype wire

// file: sim/axm_sensor_model.sv
// Behavioural sensor on the auxiliary bus that answers register reads.
`timescale 1ns/1ps
`default_nettype none
module axm_sensor_model #(
    parameter logic [6:0] DEV = 7'h1E
) (
    // Bus lines as seen on the wire.
    input  wire logic i_scl,
    input  wire logic i_sda,
    // Data pull, low drives the line low.
    output logic      o_sda_oe_n
);
    logic [7:0] sh, ptr, dat;
    logic       act, hdr, rd;
    int         n;
    initial begin
        o_sda_oe_n = 1'b1;
        act = 1'b0;
    end
    // A start or repeated start arms the address byte.
    always @(negedge i_sda) if (i_scl) begin
        act = 1'b1;
        hdr = 1'b1;
        n = 0;
    end
    // A stop ends the transfer and lets the pull-up win.
    always @(posedge i_sda) if (i_scl) begin
        act = 1'b0;
        o_sda_oe_n = 1'b1;
    end
    // Bits are taken while the clock is high.
    always @(posedge i_scl) if (act) begin
        if (n < 8) begin
            sh = {sh[6:0], i_sda};
            n++;
        end else begin
            if (rd && !hdr) begin
                ptr++;
                act = !i_sda;
            end
            hdr = 1'b0;
            n = 0;
        end
    end
    // The line changes only while the clock is low: ack, or data MSB first.
    always @(negedge i_scl) if (act) begin
        dat = ptr + 8'h30;
        if (n == 8 && hdr) begin
            rd = sh[0];
            act = (sh[7:1] == DEV);
            o_sda_oe_n = !act;
        end else if (n == 8) begin
            if (!rd) ptr = sh;
            o_sda_oe_n = rd;
        end else if (rd && !hdr) begin
            o_sda_oe_n = dat[7-n];
        end else begin
            o_sda_oe_n = 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: sim/tb.sv
// Testbench of the auxiliary sensor bus unit with a sensor on its pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [6:0] DEV = 7'h1E;
    // Stimulus, changed at the falling edge.
    logic       clk      = 1'b0;
    logic       rst      = 1'b1;
    logic       pass_req = 1'b0;
    logic       spi      = 1'b1;
    logic       start    = 1'b0;
    logic [6:0] dev      = 7'h00;
    logic [7:0] rg       = 8'h00;
    logic [7:0] len      = 8'h00;
    logic       ready    = 1'b0;
    logic       host_scl = 1'b1;
    logic       host_sda = 1'b1;
    // Outputs and the wired-and bus with pull-ups.
    logic       busy, nack, dv, host_oe_n, ck_oe, da_oe, model_oe;
    logic [7:0] data;
    wire        scl = ck_oe;
    wire        sda = da_oe & model_oe;
    int         bad_count = 0;
    int         num_checks = 0;
    always #2.5 clk = ~clk;
    axm_aux_master #(.QTR(2), .DEPTH(8)) axm_aux_master_inst (
        .i_clock(clk), .i_sys_rst(rst), .i_pass_req(pass_req), .i_host_is_spi(spi),
        .i_rd_start(start), .i_rd_dev(dev), .i_rd_reg(rg), .i_rd_len(len),
        .o_busy(busy), .o_nack(nack), .o_data_valid(dv), .o_data(data),
        .i_data_ready(ready), .i_host_scl(host_scl), .i_host_sda(host_sda),
        .o_host_sda_oe_n(host_oe_n), .i_sensor_bus_clock_pin(scl),
        .o_sensor_bus_clock_pin(), .o_sensor_bus_clock_pin_oe_n(ck_oe),
        .i_sensor_bus_data_pin(sda), .o_sensor_bus_data_pin(),
        .o_sensor_bus_data_pin_oe_n(da_oe));
    axm_sensor_model #(.DEV(DEV)) axm_sensor_model_inst (
        .i_scl(scl), .i_sda(sda), .o_sda_oe_n(model_oe));
    // Compare, count and report.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Print the counts and the verdict, then stop.
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One-cycle read request.
    task automatic request(input logic [6:0] d, input logic [7:0] r, input logic [7:0] l);
        @(negedge clk);
        dev = d;
        rg = r;
        len = l;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask
    // Bounded wait for the engine to go idle.
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (k == 3000) begin
            bad_count++;
            close_out();
        end
    endtask
    // Pop and compare bytes; the sensor returns its location plus 30h.
    task automatic drain(input int cnt, input logic [7:0] r);
        int k, t;
        k = 0;
        t = 0;
        ready = 1'b1;
        // The head shown now is popped at the coming rising edge, so judge it first.
        while (k < cnt && t < 4000) begin
            if (dv === 1'b1) begin
                check(data, r + 8'(k) + 8'h30);
                k++;
            end
            @(negedge clk);
            t++;
        end
        @(negedge clk);
        ready = 1'b0;
        check({7'h00, dv}, 8'h00);
        check(8'(k), 8'(cnt));
    endtask
    // Full read with its data.
    task automatic read_chk(input logic [7:0] r, input logic [7:0] l);
        request(DEV, r, l);
        wait_idle();
        check({7'h00, nack}, 8'h00);
        drain(int'(l), r);
    endtask
    // Fill the buffer until the bus stalls, then drain while it resumes.
    task automatic t_stall();
        int k, t;
        k = 0;
        t = 0;
        request(DEV, 8'h20, 8'h0A);
        while (k < 60 && t < 3000) begin
            @(negedge clk);
            t++;
            k = (ck_oe === 1'b0) ? k + 1 : 0;
        end
        check({6'h00, busy, dv}, 8'h03);
        check(8'(k), 8'h3C);
        drain(10, 8'h20);
        wait_idle();
    endtask
    // Pass-through: own master refused, host lines reach the sensor pins.
    task automatic t_pass();
        spi = 1'b0;
        pass_req = 1'b1;
        repeat (3) @(negedge clk);
        request(DEV, 8'h01, 8'h02);
        check({7'h00, busy}, 8'h00);
        host_scl = 1'b0;
        repeat (3) @(negedge clk);
        check({7'h00, ck_oe}, 8'h00);
        host_scl = 1'b1;
        host_sda = 1'b0;
        repeat (3) @(negedge clk);
        check({6'h00, ck_oe, da_oe}, 8'h02);
        host_sda = 1'b1;
        repeat (3) @(negedge clk);
        check({6'h00, da_oe, host_oe_n}, 8'h03);
        pass_req = 1'b0;
        repeat (3) @(negedge clk);
        read_chk(8'h40, 8'h02);
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        check({3'h0, busy, nack, dv, ck_oe, da_oe}, 8'h03);
        read_chk(8'h03, 8'h01);
        read_chk(8'h10, 8'h06);
        t_stall();
        request(7'h2B, 8'h00, 8'h02);
        wait_idle();
        check({6'h00, nack, dv}, 8'h02);
        read_chk(8'h05, 8'h01);
        request(DEV, 8'h00, 8'h00);
        check({7'h00, busy}, 8'h00);
        t_pass();
        spi = 1'b1;
        pass_req = 1'b1;
        repeat (3) @(negedge clk);
        read_chk(8'h60, 8'h02);
        check({7'h00, host_oe_n}, 8'h01);
        close_out();
    end
endmodule
`default_nettype wire
